// File: ewp_target.sv
// Target end: protection register, identification page, write gating.
// Assumes the bench loops nv_* back as non-volatile storage and models
// the main array from arr_* strobes.
`timescale 1ns/10ps
module ewp_target
   import ewp_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_n,
   ewp_if.device            bus,
   input  wire logic [2:0]  ce_addr,
   input  wire logic        wc_pin,
   input  wire logic [3:0]  nv_cfg_in,
   input  wire logic        nv_idlock_in,
   output logic      [3:0]  nv_cfg_q,
   output logic             nv_idlock_q,
   output logic             nv_wr,
   output logic             arr_byte_stb,
   output logic      [15:0] arr_addr,
   output logic      [7:0]  arr_data,
   output logic             arr_commit,
   input  wire logic [7:0]  arr_rdata
);
   typedef struct packed {
      logic [2:0]                  scl_s;
      logic [2:0]                  sda_s;
      logic [1:0]                  wc_s;
      ewp_phase_t                  phase;
      ewp_tgt_t                    tgt;
      logic [3:0]                  bitcnt;
      logic [7:0]                  shreg;
      logic [7:0]                  rdsh;
      logic                        ackslot;
      logic                        acked;
      logic                        tenth;
      logic                        rd_first;
      logic                        is_cfg;
      logic [15:0]                 addr;
      logic [1:0]                  nbytes;
      logic [7:0]                  swp_pend;
      logic [3:0]                  cfg;
      logic                        idlock;
      logic                        loaded;
      logic                        sda_oe;
      logic                        nv_wr;
      logic                        arr_stb;
      logic                        arr_commit;
      logic [7:0]                  arr_data;
      logic [IDP_BYTES-1:0][7:0]   page;
      logic [IDP_BYTES-1:0][7:0]   stage;
   } ewp_tgt_state_t;

   ewp_tgt_state_t q;
   ewp_tgt_state_t d;
   logic           scl_h;
   logic           sda_h;
   logic           rise_ev;
   logic           fall_ev;
   logic           start_ev;
   logic           stop_ev;
   logic           wc_h;
   logic           wr_ok;
   logic [7:0]     rd_val;

   // ==========================================================
   // Helpers
   // Region check: protected when address quarter reaches the threshold
   function automatic logic is_protected(input logic [3:0] cfg, input logic [15:0] a);
      is_protected = cfg[CFG_EN_BIT] &&
         (a[15:14] >= (SIZE_ALL - cfg[CFG_SIZE_HI:CFG_SIZE_LO]));
   endfunction

   // Next byte address; page accesses roll over inside 128 bytes
   function automatic logic [15:0] next_addr(input logic [15:0] a, input logic wrap);
      logic [IDP_AW-1:0] lo;
      lo = a[IDP_AW-1:0] + 1'b1;
      if (wrap) begin
         next_addr = {a[15:IDP_AW], lo};
      end else begin
         next_addr = a + 16'h0001;
      end
   endfunction

   // ==========================================================
   // Bus events from the second and third synchroniser stages
   assign scl_h    = q.scl_s[1];
   assign sda_h    = q.sda_s[1];
   assign wc_h     = q.wc_s[1];
   assign rise_ev  = scl_h && !q.scl_s[2];
   assign fall_ev  = !scl_h && q.scl_s[2];
   assign start_ev = scl_h && q.scl_s[2] && !sda_h && q.sda_s[2];
   assign stop_ev  = scl_h && q.scl_s[2] && sda_h && !q.sda_s[2];

   // Data byte may be acked only if the target is writable
   assign wr_ok = !wc_h &&
      ((q.tgt == TGT_SWP) ? !q.cfg[CFG_LOCK_BIT] :
       (q.tgt == TGT_IDP) ? !q.idlock :
       (q.tgt == TGT_MEM) ? !is_protected(q.cfg, q.addr) : 1'b0);

   // Read source; reserved bits of the register read as zero
   assign rd_val = (q.tgt == TGT_SWP) ? {RSVD_ZERO, q.cfg} :
                   (q.tgt == TGT_IDP) ? q.page[q.addr[IDP_AW-1:0]] :
                   (q.tgt == TGT_MEM) ? arr_rdata : IDP_ERASED;

   // ==========================================================
   // Next-state logic
   always_comb begin
      d            = q;
      d.nv_wr      = 1'b0;
      d.arr_stb    = 1'b0;
      d.arr_commit = 1'b0;
      d.scl_s      = {q.scl_s[1:0], bus.scl};
      d.sda_s      = {q.sda_s[1:0], bus.sda};
      d.wc_s       = {q.wc_s[0], wc_pin};
      // Stored image taken once, the cycle after reset release
      if (!q.loaded) begin
         d.loaded = 1'b1;
         d.cfg    = nv_cfg_in;
         d.idlock = nv_idlock_in;
      end
      if (start_ev) begin
         d.phase   = P_DEV;
         d.bitcnt  = BIT_ZERO;
         d.ackslot = 1'b0;
         d.sda_oe  = 1'b0;
         d.tenth   = 1'b0;
      end else if (stop_ev) begin
         // Commit only for a stop right after a data ack
         if (q.tenth && q.bitcnt == BIT_ONE && q.phase == P_WR && q.nbytes != BIT_ZERO[1:0]) begin
            unique case (q.tgt)
               TGT_SWP: begin
                  if (q.nbytes == NB_ONE) begin
                     d.cfg   = q.swp_pend[3:0];
                     d.nv_wr = 1'b1;
                  end
               end
               TGT_IDP:  d.page = q.stage;
               TGT_MEM:  d.arr_commit = 1'b1;
               TGT_NONE: ;
            endcase
         end
         d.phase   = P_IDLE;
         d.ackslot = 1'b0;
         d.sda_oe  = 1'b0;
         d.tenth   = 1'b0;
      end else if (rise_ev) begin
         if (q.ackslot) begin
            // Controller ack on a read; a nack ends the read
            if (q.phase == P_RD && !q.rd_first) begin
               if (sda_h) begin
                  d.phase = P_IDLE;
               end else begin
                  d.addr = next_addr(q.addr, q.tgt == TGT_IDP);
               end
            end
         end else if (q.phase != P_IDLE && q.bitcnt < BYTE_BITS) begin
            d.shreg  = {q.shreg[6:0], sda_h};
            d.bitcnt = q.bitcnt + BIT_ONE;
         end
      end else if (fall_ev && q.phase != P_IDLE) begin
         if (q.ackslot) begin
            // End of ack slot: release, or present next read byte
            d.ackslot  = 1'b0;
            d.bitcnt   = BIT_ZERO;
            d.sda_oe   = 1'b0;
            d.rd_first = 1'b0;
            d.tenth    = q.acked && q.phase == P_WR;
            if (q.acked && q.phase == P_WR) begin
               d.addr = next_addr(q.addr, 1'b1);
            end
            if (q.phase == P_RD) begin
               d.rdsh   = {rd_val[6:0], 1'b0};
               d.sda_oe = !rd_val[7];
            end
         end else if (q.bitcnt == BYTE_BITS) begin
            d.ackslot = 1'b1;
            d.acked   = 1'b0;
            unique case (q.phase)
               P_DEV: begin
                  if ((q.shreg[7:4] == DEV_TYPE_MEM || q.shreg[7:4] == DEV_TYPE_CFG) &&
                      q.shreg[3:1] == ce_addr) begin
                     d.sda_oe = 1'b1;
                     d.acked  = 1'b1;
                     d.is_cfg = (q.shreg[7:4] == DEV_TYPE_CFG);
                     if (q.shreg[0]) begin
                        d.phase    = P_RD;
                        d.rd_first = 1'b1;
                        if (q.shreg[7:4] == DEV_TYPE_MEM) begin
                           d.tgt = TGT_MEM;
                        end
                     end else begin
                        d.phase = P_AHI;
                     end
                  end else begin
                     d.phase = P_IDLE;
                  end
               end
               P_AHI: begin
                  d.addr[15:8] = q.shreg;
                  d.sda_oe     = 1'b1;
                  d.acked      = 1'b1;
                  d.phase      = P_ALO;
                  if (!q.is_cfg) begin
                     d.tgt = TGT_MEM;
                  end else if (q.shreg[7:5] == SEL_SWP) begin
                     d.tgt = TGT_SWP;
                  end else if (q.shreg[7:5] == SEL_IDP) begin
                     d.tgt = TGT_IDP;
                  end else begin
                     d.tgt = TGT_NONE;
                  end
               end
               P_ALO: begin
                  // Low address byte: always acked, as for the array
                  d.addr[7:0] = q.shreg;
                  d.sda_oe    = 1'b1;
                  d.acked     = 1'b1;
                  d.phase     = P_WR;
                  d.nbytes    = BIT_ZERO[1:0];
                  d.stage     = q.page;
               end
               P_WR: begin
                  if (wr_ok) begin
                     d.sda_oe = 1'b1;
                     d.acked  = 1'b1;
                     d.nbytes = (q.nbytes == BIT_ZERO[1:0]) ? NB_ONE : NB_MANY;
                     unique case (q.tgt)
                        TGT_SWP:  d.swp_pend = q.shreg;
                        TGT_IDP:  d.stage[q.addr[IDP_AW-1:0]] = q.shreg;
                        TGT_MEM: begin
                           d.arr_stb  = 1'b1;
                           d.arr_data = q.shreg;
                        end
                        TGT_NONE: ;
                     endcase
                  end
               end
               P_RD:   d.sda_oe = 1'b0;
               P_IDLE: ;
            endcase
         end else begin
            d.tenth = 1'b0;
            if (q.phase == P_RD && q.bitcnt != BIT_ZERO) begin
               d.sda_oe = !q.rdsh[7];
               d.rdsh   = {q.rdsh[6:0], 1'b0};
            end
         end
      end
   end

   // ==========================================================
   // State register; page resets to erased, register to factory zero
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         q         <= '0;
         q.scl_s   <= '1;
         q.sda_s   <= '1;
         q.tgt     <= TGT_NONE;
         q.cfg     <= CFG_RESET;
         q.page    <= {IDP_BYTES{IDP_ERASED}};
         q.stage   <= {IDP_BYTES{IDP_ERASED}};
      end else begin
         q <= d;
      end
   end

   // ==========================================================
   // Outputs straight from state
   assign bus.dev_sda_o  = 1'b0;
   assign bus.dev_sda_oe = q.sda_oe;
   assign nv_cfg_q       = q.cfg;
   assign nv_idlock_q    = q.idlock;
   assign nv_wr          = q.nv_wr;
   assign arr_byte_stb   = q.arr_stb;
   assign arr_addr       = q.addr;
   assign arr_data       = q.arr_data;
   assign arr_commit     = q.arr_commit;
endmodule

// File: ewp_pkg.sv
// Shared constants and types for the write-protect / identification-page
// target and its two-wire controller. Assumes both ends compile against it.
package ewp_pkg;
   // ==========================================================
   // Select and address decode
   localparam logic [3:0] DEV_TYPE_MEM = 4'hA;
   localparam logic [3:0] DEV_TYPE_CFG = 4'hB;
   localparam logic [2:0] SEL_SWP      = 3'h5;
   localparam logic [2:0] SEL_IDP      = 3'h0;
   localparam logic [3:0] BYTE_BITS    = 4'h8;
   localparam logic [3:0] BIT_ZERO     = 4'h0;
   localparam logic [3:0] BIT_ONE      = 4'h1;
   localparam logic [1:0] NB_ONE       = 2'h1;
   localparam logic [1:0] NB_MANY      = 2'h2;
   // ==========================================================
   // Protection register layout and reset values
   localparam int         CFG_LOCK_BIT = 0;
   localparam int         CFG_SIZE_LO  = 1;
   localparam int         CFG_SIZE_HI  = 2;
   localparam int         CFG_EN_BIT   = 3;
   localparam logic [3:0] CFG_RESET    = 4'h0;
   localparam logic [3:0] RSVD_ZERO    = 4'h0;
   localparam logic [1:0] SIZE_ALL     = 2'h3;
   localparam logic [7:0] IDP_ERASED   = 8'hFF;
   localparam int         IDP_BYTES    = 128;
   localparam int         IDP_AW       = 7;
   // ==========================================================
   // Controller register map and timing
   localparam logic [3:0] CMD_OFS      = 4'h0;
   localparam logic [3:0] STAT_OFS     = 4'h4;
   localparam int         CMD_START    = 8;
   localparam int         CMD_XFER     = 9;
   localparam int         CMD_READ     = 10;
   localparam int         CMD_NACK     = 11;
   localparam int         CMD_STOP     = 12;
   localparam int         CLK_PERIOD_NS = 25;
   localparam int         SCL_PERIOD_NS = 10000;
   localparam int         QTR_CYC       = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
   // ==========================================================
   // Enumerations
   typedef enum logic [2:0] {
      P_IDLE = 3'b000, P_DEV = 3'b001, P_AHI = 3'b010,
      P_ALO  = 3'b011, P_WR  = 3'b100, P_RD  = 3'b101
   } ewp_phase_t;
   typedef enum logic [1:0] {
      TGT_MEM = 2'b00, TGT_SWP = 2'b01, TGT_IDP = 2'b10, TGT_NONE = 2'b11
   } ewp_tgt_t;
   typedef enum logic [1:0] {
      H_IDLE = 2'b00, H_START = 2'b01, H_BIT = 2'b10, H_STOP = 2'b11
   } ewp_hst_t;
endpackage

// File: ewp_if.sv
// Two-wire link between the target and the controller.
// Assumes open-drain data: the wire is low while either end enables.
`timescale 1ns/10ps
interface ewp_if;
   logic scl;
   logic sda;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic host_sda_o;
   logic host_sda_oe;
   // ==========================================================
   // Wired-AND resolution of the data line
   assign sda = !((dev_sda_oe && !dev_sda_o) || (host_sda_oe && !host_sda_o));
   modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
   modport host (output scl, input sda, output host_sda_o, output host_sda_oe);
endinterface

// File: ewp_ctrl.sv
// Controller end: byte-level two-wire master behind a Wishbone slave.
// Assumes software sequences start/byte/stop commands to build frames.
`timescale 1ns/10ps
module ewp_ctrl
   import ewp_pkg::*;
#(
   parameter int QTR = QTR_CYC
)
(
   input  wire logic        mclk,
   input  wire logic        rst_n,
   ewp_if.host              bus,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o
);
   typedef struct packed {
      logic [1:0]  sda_s;
      ewp_hst_t    st;
      logic [1:0]  qph;
      logic [15:0] div;
      logic [3:0]  bitn;
      logic [7:0]  tx;
      logic [7:0]  sh;
      logic [7:0]  rx;
      logic        c_xfer;
      logic        c_rd;
      logic        c_nack;
      logic        c_stop;
      logic        busy;
      logic        rxack;
      logic        scl;
      logic        sda_oe;
      logic        wb_ack;
      logic [31:0] wb_dat;
   } ewp_ctrl_state_t;

   ewp_ctrl_state_t q;
   ewp_ctrl_state_t d;
   logic            tick;

   // Quarter-period tick of the generated bus clock
   assign tick = (q.div == 16'(QTR - 1));

   // ==========================================================
   // Next-state logic
   always_comb begin
      d        = q;
      d.sda_s  = {q.sda_s[0], bus.sda};
      d.wb_ack = 1'b0;
      // Bus slave: one wait state, commands refused while busy
      if (wb_cyc_i && wb_stb_i && !q.wb_ack) begin
         d.wb_ack = 1'b1;
         d.wb_dat = '0;
         if (wb_we_i) begin
            if (wb_adr_i == CMD_OFS && !q.busy) begin
               if (wb_sel_i[0]) begin
                  d.tx = wb_dat_i[7:0];
               end
               if (wb_sel_i[1]) begin
                  d.sh     = wb_sel_i[0] ? wb_dat_i[7:0] : q.tx;
                  d.c_xfer = wb_dat_i[CMD_XFER];
                  d.c_rd   = wb_dat_i[CMD_READ];
                  d.c_nack = wb_dat_i[CMD_NACK];
                  d.c_stop = wb_dat_i[CMD_STOP];
                  d.qph    = 2'h0;
                  d.div    = 16'h0000;
                  d.bitn   = BIT_ZERO;
                  d.st     = wb_dat_i[CMD_START] ? H_START :
                             wb_dat_i[CMD_XFER]  ? H_BIT   :
                             wb_dat_i[CMD_STOP]  ? H_STOP  : H_IDLE;
                  d.busy   = wb_dat_i[CMD_START] | wb_dat_i[CMD_XFER] | wb_dat_i[CMD_STOP];
               end
            end
         end else if (wb_adr_i == STAT_OFS) begin
            d.wb_dat = {16'h0000, q.rx, 6'h00, q.rxack, q.busy};
         end else if (wb_adr_i == CMD_OFS) begin
            d.wb_dat = {24'h000000, q.tx};
         end
      end
      // Bit engine, four quarters per bus clock
      if (q.st != H_IDLE) begin
         d.div = tick ? 16'h0000 : q.div + 16'h0001;
         if (tick) begin
            d.qph = q.qph + 2'h1;
            unique case (q.st)
               H_START: begin
                  unique case (q.qph)
                     2'h0: d.sda_oe = 1'b0;
                     2'h1: d.scl = 1'b1;
                     2'h2: d.sda_oe = 1'b1;
                     2'h3: begin
                        d.scl = 1'b0;
                        d.st  = q.c_xfer ? H_BIT : q.c_stop ? H_STOP : H_IDLE;
                     end
                  endcase
               end
               H_BIT: begin
                  unique case (q.qph)
                     2'h0: d.sda_oe = (q.bitn < BYTE_BITS) ? (!q.c_rd && !q.sh[7]) : (q.c_rd && !q.c_nack);
                     2'h1: d.scl = 1'b1;
                     2'h2: begin
                        if (q.bitn < BYTE_BITS) begin
                           d.sh = {q.sh[6:0], q.sda_s[1]};
                        end else begin
                           d.rxack = q.sda_s[1];
                        end
                     end
                     2'h3: begin
                        d.scl = 1'b0;
                        if (q.bitn == BYTE_BITS) begin
                           d.rx   = q.sh;
                           d.bitn = BIT_ZERO;
                           d.st   = q.c_stop ? H_STOP : H_IDLE;
                        end else begin
                           d.bitn = q.bitn + BIT_ONE;
                        end
                     end
                  endcase
               end
               H_STOP: begin
                  unique case (q.qph)
                     2'h0: d.sda_oe = 1'b1;
                     2'h1: d.scl = 1'b1;
                     2'h2: d.sda_oe = 1'b0;
                     2'h3: d.st = H_IDLE;
                  endcase
               end
               H_IDLE: ;
            endcase
            if (d.st == H_IDLE) begin
               d.busy = 1'b0;
            end
         end
      end
   end

   // ==========================================================
   // State register; bus lines idle released and high
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         q       <= '0;
         q.sda_s <= '1;
         q.scl   <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign bus.scl         = q.scl;
   assign bus.host_sda_o  = 1'b0;
   assign bus.host_sda_oe = q.sda_oe;
   assign wb_dat_o        = q.wb_dat;
   assign wb_ack_o        = q.wb_ack;
endmodule

// File: ewp_checker.sv
// Wire-level checks on the two-wire link between target and controller.
// Assumes the controller runs with a quarter period of 4 mclk cycles.
`timescale 1ns/10ps
module ewp_checker (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic scl,
   input wire logic sda,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe,
   input wire logic host_sda_o,
   input wire logic host_sda_oe
);
   // ==========================================================
   // Link properties
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Open drain: a driven line is always pulled low
   a_dev_open_drain: assert property (dev_sda_oe |-> !dev_sda_o) else $error("target drives sda high");
   a_host_open_drain: assert property (host_sda_oe |-> !host_sda_o) else $error("controller drives sda high");
   // Target only moves sda while scl is low, so it never fakes start or stop
   a_dev_take_low: assert property ($rose(dev_sda_oe) |-> !scl) else $error("target pulls sda with scl high");
   a_dev_drop_low: assert property ($fell(dev_sda_oe) |-> !scl) else $error("target frees sda with scl high");
   a_dev_hold_bit: assert property ($rose(dev_sda_oe) |-> dev_sda_oe [*8]) else $error("target bit too short");
   a_start_by_host: assert property (scl && $fell(sda) |-> host_sda_oe) else $error("start not made by controller");
   a_stop_by_host: assert property (scl && $rose(sda) |-> $past(host_sda_oe)) else $error("stop not made by controller");
   // Clock phases last two quarters each
   a_scl_high_len: assert property ($rose(scl) |-> scl [*8]) else $error("scl high phase too short");
   a_scl_low_len: assert property ($fell(scl) |-> !scl [*8]) else $error("scl low phase too short");
endmodule

// File: eeprom_write_protect_and_id_page_test.sv
// Bench: software frames over Wishbone, target judged by ack bits and reads.
// Assumes the package, interface, both ends and the checker compile first.
`timescale 1ns/10ps
module eeprom_write_protect_and_id_page_test;
   import ewp_pkg::*;
   logic        mclk, rst_n, wc_pin, nv_idlock_in, nv_idlock_q, nv_wr, cyc, stb, we, ack, arr_stb, arr_commit;
   logic [3:0]  adr, nv_cfg_q;
   logic [3:0]  nv_cfg_in = 4'h0;
   logic [7:0]  arr_data;
   logic [7:0]  arr_last = 8'h00;
   int          commits = 0;
   logic [15:0] arr_addr;
   logic [31:0] wdat, rdat, got;
   int          fail_count, check_count;
   ewp_if bus ();
   ewp_target i_ewp_target (.mclk(mclk), .rst_n(rst_n), .bus(bus), .ce_addr(3'h0), .wc_pin(wc_pin),
      .nv_cfg_in(nv_cfg_in), .nv_idlock_in(nv_idlock_in), .nv_cfg_q(nv_cfg_q), .nv_idlock_q(nv_idlock_q),
      .nv_wr(nv_wr), .arr_byte_stb(arr_stb), .arr_addr(arr_addr), .arr_data(arr_data), .arr_commit(arr_commit),
      .arr_rdata(arr_addr[7:0]));
   ewp_ctrl #(.QTR(4)) i_ewp_ctrl (.mclk(mclk), .rst_n(rst_n), .bus(bus), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
   ewp_checker i_ewp_checker (.mclk(mclk), .rst_n(rst_n), .scl(bus.scl), .sda(bus.sda),
      .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe), .host_sda_o(bus.host_sda_o),
      .host_sda_oe(bus.host_sda_oe));
   // ==========================================================
   // Clock and non-volatile store
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // Image survives resets, like the cells behind the register
   always @(posedge mclk) if (nv_wr === 1'b1) nv_cfg_in <= nv_cfg_q;
   // Array side: count commit pulses, keep the last byte handed over
   always @(posedge mclk) begin
      if (arr_commit === 1'b1) commits <= commits + 1;
      if (arr_stb === 1'b1) arr_last <= arr_data;
   end
   // ==========================================================
   // Shared tasks
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Classic cycle held until ack is seen at an edge
   task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
      for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge mclk);
      got = rdat;
      cyc <= 1'b0; stb <= 1'b0;
      if (n == 20) begin fail_count++; wrap_up; end
   endtask
   // One command, then poll busy; nk is the expected ack bit
   task op(input logic [31:0] c, input logic [7:0] b, input logic nk);
      int n;
      wb(1'b1, CMD_OFS, c | {24'h0, b});
      for (n = 0; n < 500; n++) begin
         wb(1'b0, STAT_OFS, 32'h0);
         if (got[0] === 1'b0) break;
      end
      if (n == 500) begin fail_count++; wrap_up; end
      chk({7'h0, got[1]}, {7'h0, nk});
   endtask
   task hdr(input logic [7:0] s, input logic [7:0] a1);
      op(32'h0300, s, 1'b0);
      op(32'h0200, a1, 1'b0);
      op(32'h0200, 8'h85, 1'b0);
   endtask
   task wr1(input logic [7:0] s, input logic [7:0] a1, input logic [7:0] d, input logic nk);
      hdr(s, a1);
      op(32'h1200, d, nk);
   endtask
   // Random read: restart, one byte, master nack and stop
   task rd1(input logic [7:0] a1);
      hdr(8'hB0, a1);
      op(32'h0300, 8'hB1, 1'b0);
      op(32'h1E00, 8'h00, 1'b1);
   endtask
   task nvchk(input logic [3:0] e);
      repeat (8) @(posedge mclk);
      chk({4'h0, nv_cfg_q}, {4'h0, e});
   endtask
   task rst(input logic lk);
      rst_n <= 1'b0; nv_idlock_in <= lk;
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (6) @(posedge mclk);
   endtask
   // ==========================================================
   // Scenarios
   task t_reg;
      rd1(8'hBF); chk(got[15:8], 8'h00);
      wc_pin <= 1'b1; wr1(8'hB0, 8'hBF, 8'h08, 1'b1); wc_pin <= 1'b0;
      hdr(8'hB0, 8'hBF); op(32'h0200, 8'h08, 1'b0); op(32'h1200, 8'h08, 1'b0);
      nvchk(4'h0);
      $display("test t_reg done");
   endtask
   task t_prot;
      wr1(8'hB0, 8'hBF, 8'h08, 1'b0); nvchk(4'h8);
      wr1(8'hA0, 8'hC0, 8'h55, 1'b1);
      wr1(8'hA0, 8'h80, 8'h55, 1'b0);
      chk(commits[7:0], 8'h01);
      chk(arr_last, 8'h55);
      // Stop right after the address bytes: no data, so no write cycle
      hdr(8'hA0, 8'h40);
      op(32'h1000, 8'h00, 1'b0);
      chk(commits[7:0], 8'h01);
      wr1(8'hB0, 8'hBF, 8'hFB, 1'b0); rd1(8'hBF); chk(got[15:8], 8'h0B);
      wr1(8'hA0, 8'h80, 8'h55, 1'b1); wr1(8'hA0, 8'h40, 8'h55, 1'b0);
      wr1(8'hB0, 8'hBF, 8'h00, 1'b1); nvchk(4'hB);
      $display("test t_prot done");
   endtask
   task t_idp;
      rd1(8'h1F); chk(got[15:8], 8'hFF);
      wr1(8'hB0, 8'h1F, 8'h3C, 1'b0); rd1(8'h1F); chk(got[15:8], 8'h3C);
      $display("test t_idp done");
   endtask
   // Power cycle with the page lock set in storage
   task t_pwr;
      rst(1'b1);
      chk({7'h0, nv_idlock_q}, 8'h01);
      rd1(8'hBF); chk(got[15:8], 8'h0B);
      wr1(8'hB0, 8'h1F, 8'hC3, 1'b1); rd1(8'h1F); chk(got[15:8], 8'hFF);
      $display("test t_pwr done");
   endtask
   initial begin
      rst_n = 1'b0; wc_pin = 1'b0; nv_idlock_in = 1'b0; cyc = 1'b0; stb = 1'b0;
      we = 1'b0; adr = 4'h0; wdat = 32'h0; got = 32'h0; fail_count = 0; check_count = 0;
      rst(1'b0);
      t_reg;
      t_prot;
      t_idp;
      t_pwr;
      wrap_up;
   end
endmodule
